// *** rtl/rom_ram_io_port_combo.sv ***
`timescale 1ns/10ps
`default_nettype none

module rom_ram_io_port_combo
	import combo_pkg::*;
#(
	parameter logic [7:0] ROM_SEED = 8'h5A    // Mask pattern seed, arbitrary
)
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       init_clear_n,
	// Processor bus
	input  wire logic [9:0] cpu_address_lines,
	input  wire logic       rom_select_line,
	input  wire logic       chip_select_1,
	input  wire logic       read_not_write,
	input  wire logic [7:0] cpu_data_bus_in,
	output logic      [7:0] cpu_data_bus_out,
	output logic            cpu_data_bus_oe,
	// Port A pins
	input  wire logic [7:0] port_a_pins_in,
	output logic      [7:0] port_a_pins_out,
	output logic      [7:0] port_a_pins_oe,
	output logic      [7:0] port_a_pullup_en,
	// Port B pins
	input  wire logic [7:0] port_b_pins_in,
	output logic      [7:0] port_b_pins_out,
	output logic      [7:0] port_b_pins_oe,
	output logic      [7:0] port_b_pullup_en,
	// Interrupt level, active low
	output logic            timer_interrupt_n
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------

	// Clear and bus decode
	logic             clear;
	bus_req_t         req;
	target_t          target;
	logic             dev_sel;
	logic             wr_any;
	logic             rd_any;
	logic             wr_port;
	logic             wr_ram;
	logic             rd_hit;
	logic [3:0]       port_wr_sel;

	// Port registers and pin synchronisers
	port_regs_t       port_a_q;
	port_regs_t       port_b_q;
	logic [7:0]       pa_meta_q;
	logic [7:0]       pa_sync_q;
	logic [7:0]       pb_meta_q;
	logic [7:0]       pb_sync_q;

	// Memories
	logic [7:0]       ram_mem [0:RAM_DEPTH-1];
	logic [7:0]       rom_mem [0:ROM_DEPTH-1];
	logic [7:0]       ram_rd;
	logic [7:0]       rom_rd;

	// Interval timer
	logic [7:0]       tmr_rd;
	logic             tmr_irq;
	logic             tmr_wr;
	logic             tmr_rd_en;

	// Read path
	logic [7:0]       rd_mux;
	logic [7:0]       rd_data_q;
	logic             rd_oe_q;

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// One byte of the masked ROM contents
	function automatic logic [7:0] rom_byte(input logic [9:0] a);
		rom_byte = a[7:0] ^ {a[9:8], a[9:8], a[9:8], a[9:8]} ^ ROM_SEED;
	endfunction : rom_byte

	// Pin view for inputs, stored bit for outputs
	function automatic logic [7:0] port_view(
		input logic [7:0] pins,
		input port_regs_t regs
	);
		port_view = (pins & ~regs.dir) | (regs.data & regs.dir);
	endfunction : port_view

	// One-hot pick of the port register named by the low address lines
	function automatic logic [3:0] port_strobe(input logic [1:0] ofs);
		port_strobe = 4'h1 << ofs;
	endfunction : port_strobe

	// Resolve an access to at most one resource
	function automatic target_t decode(input bus_req_t r, input logic sel);
		target_t t;
		t = TGT_NONE;
		// ROM select wins; chip_select_1 splits the RAM from the I/O page
		if (sel) begin
			if (r.rsel) begin
				t = TGT_ROM;
			end else if (r.cs1 && (r.addr[9:6] == RAM_PAGE)) begin
				t = TGT_RAM;
			end else if (!r.cs1 && (r.addr[9:6] == IO_PAGE)) begin
				if (r.addr[TMR_BIT]) begin
					t = TGT_TIMER;
				end else begin
					t = TGT_PORT;
				end
			end
		end
		decode = t;
	endfunction : decode

	// ----------------------------------------
	// Reset and bus request
	// ----------------------------------------

	// Either the system reset or the clear pin clears the block
	// The clear pin is a level on this clock; one edge low is enough
	assign clear = rst || !init_clear_n;

	// Bus signals arrive on the same phase-two clock
	assign req = '{
		rnw:  read_not_write,
		rsel: rom_select_line,
		cs1:  chip_select_1,
		addr: cpu_address_lines
	};

	// Port B bit 6 is read as the device select
	// It comes from the processor's decode on this clock, so no synchroniser
	assign dev_sel = (port_b_pins_in[CS_PIN] == CS_ACTIVE);

	// Decode never depends on port setup
	assign target = decode(req, dev_sel);

	// Read or write qualifiers, both off during clear
	assign wr_any = !clear && !req.rnw;
	assign rd_any = !clear && req.rnw;

	// Access strobes per resource; a deselected or cleared cycle raises none
	assign wr_port     = wr_any && (target == TGT_PORT);
	assign wr_ram      = wr_any && (target == TGT_RAM);
	assign rd_hit      = rd_any && (target != TGT_NONE);
	assign port_wr_sel = wr_port ? port_strobe(req.addr[1:0]) : 4'h0;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------

	// Pin reads lag the pins by two clocks; software must allow for it
	// Port A pins pass two flip-flops before use
	always_ff @(posedge ref_clk) begin
		pa_meta_q <= port_a_pins_in;
		pa_sync_q <= pa_meta_q;
	end

	// Port B pins pass two flip-flops before use
	always_ff @(posedge ref_clk) begin
		pb_meta_q <= port_b_pins_in;
		pb_sync_q <= pb_meta_q;
	end

	// ----------------------------------------
	// Port registers
	// ----------------------------------------

	// Port A direction and data, written only by the processor
	always_ff @(posedge ref_clk) begin
		if (clear) begin
			port_a_q.dir  <= BYTE_CLEAR;
			port_a_q.data <= BYTE_CLEAR;
		end else begin
			if (port_wr_sel[OFS_A_DIR]) begin
				port_a_q.dir <= cpu_data_bus_in;
			end
			if (port_wr_sel[OFS_A_DATA]) begin
				port_a_q.data <= cpu_data_bus_in;
			end
		end
	end

	// Port B direction and data, written only by the processor
	always_ff @(posedge ref_clk) begin
		if (clear) begin
			port_b_q.dir  <= BYTE_CLEAR;
			port_b_q.data <= BYTE_CLEAR;
		end else begin
			if (port_wr_sel[OFS_B_DIR]) begin
				port_b_q.dir <= cpu_data_bus_in;
			end
			if (port_wr_sel[OFS_B_DATA]) begin
				port_b_q.data <= cpu_data_bus_in;
			end
		end
	end

	// ----------------------------------------
	// Port pin drive
	// ----------------------------------------

	// Port A: output bits drive data, input bits sit at 1 with pull-up
	always_comb begin
		port_a_pins_oe   = port_a_q.dir;
		port_a_pins_out  = port_a_q.data | ~port_a_q.dir;
		port_a_pullup_en = ~port_a_q.dir;
	end

	// Port B: bit 6 never driven, bit 7 open-collector with the interrupt
	always_comb begin
		port_b_pins_oe   = port_b_q.dir;
		port_b_pins_out  = port_b_q.data | ~port_b_q.dir;
		port_b_pullup_en = ~port_b_q.dir;
		// Chip select pin is input only
		port_b_pins_oe[CS_PIN]   = 1'b0;
		port_b_pins_out[CS_PIN]  = 1'b1;
		port_b_pullup_en[CS_PIN] = 1'b0;
		// Bit 7 pulls low for an interrupt, never pulled up
		// An interrupt overrides bit 7 even where it is set up as an output
		port_b_pullup_en[IRQ_PIN] = 1'b0;
		if (tmr_irq) begin
			port_b_pins_oe[IRQ_PIN]  = 1'b1;
			port_b_pins_out[IRQ_PIN] = 1'b0;
		end
	end

	// Interrupt level mirrored on its own output
	assign timer_interrupt_n = !tmr_irq;

	// ----------------------------------------
	// Memories
	// ----------------------------------------

	// RAM byte chosen by the six low address lines
	always_ff @(posedge ref_clk) begin
		if (wr_ram) begin
			ram_mem[req.addr[5:0]] <= cpu_data_bus_in;
		end
	end

	assign ram_rd = ram_mem[req.addr[5:0]];

	// Mask contents are fixed by the seed; the array reads like any memory
	for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_rom
		assign rom_mem[i] = rom_byte(10'(i));
	end

	// ROM spans all ten address lines
	assign rom_rd = rom_mem[req.addr];

	// ----------------------------------------
	// Interval timer
	// ----------------------------------------
	assign tmr_wr    = wr_any && (target == TGT_TIMER);
	assign tmr_rd_en = rd_any && (target == TGT_TIMER);

	interval_timer u_timer (
		.ref_clk (ref_clk),
		.clear   (clear),
		.wr_en   (tmr_wr),
		.rd_en   (tmr_rd_en),
		.reg_sel (req.addr[3:0]),
		.wr_data (cpu_data_bus_in),
		.rd_data (tmr_rd),
		.irq     (tmr_irq)
	);

	// ----------------------------------------
	// Read path
	// ----------------------------------------

	// Select the answering resource; reads never touch port registers
	always_comb begin
		rd_mux = BYTE_CLEAR;
		unique case (target)
			TGT_ROM:   rd_mux = rom_rd;
			TGT_RAM:   rd_mux = ram_rd;
			TGT_TIMER: rd_mux = tmr_rd;
			TGT_PORT: begin
				unique case (req.addr[1:0])
					OFS_A_DATA: rd_mux = port_view(pa_sync_q, port_a_q);
					OFS_A_DIR:  rd_mux = port_a_q.dir;
					OFS_B_DATA: rd_mux = port_view(pb_sync_q, port_b_q);
					OFS_B_DIR:  rd_mux = port_b_q.dir;
				endcase
			end
			TGT_NONE:  rd_mux = BYTE_CLEAR;
		endcase
	end

	// Read data registered at the edge ending the read cycle
	// Unmapped cycles keep the last byte; the enable stays low then
	always_ff @(posedge ref_clk) begin
		if (clear) begin
			rd_data_q <= BYTE_CLEAR;
		end else if (rd_hit) begin
			rd_data_q <= rd_mux;
		end
	end

	// Drivers on only for a selected read, off through reset
	always_ff @(posedge ref_clk) begin
		if (clear) begin
			rd_oe_q <= 1'b0;
		end else begin
			rd_oe_q <= rd_hit;
		end
	end

	// Gating with clear drops the drivers at once, before any clock edge
	assign cpu_data_bus_out = rd_data_q;
	assign cpu_data_bus_oe  = rd_oe_q && !clear;

endmodule : rom_ram_io_port_combo

`default_nettype wire

// *** rtl/combo_pkg.sv ***
package combo_pkg;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int          ROM_DEPTH  = 1024;
	localparam int          RAM_DEPTH  = 64;
	localparam logic [7:0]  BYTE_CLEAR = 8'h00;

	// ----------------------------------------
	// Address decode (upper address lines and selects)
	// ----------------------------------------
	localparam logic [3:0]  RAM_PAGE   = 4'hE;    // A9..A6 pattern for the RAM
	localparam logic [3:0]  IO_PAGE    = 4'hD;    // A9..A6 pattern for ports and timer
	localparam logic        CS_ACTIVE  = 1'b1;    // Level on port_b_bit6 that selects the device
	localparam int          TMR_BIT    = 2;       // A2 splits ports from timer

	// Port register offsets within the I/O page (A1..A0)
	localparam logic [1:0]  OFS_A_DATA = 2'h0;
	localparam logic [1:0]  OFS_A_DIR  = 2'h1;
	localparam logic [1:0]  OFS_B_DATA = 2'h2;
	localparam logic [1:0]  OFS_B_DIR  = 2'h3;

	// ----------------------------------------
	// Port B pin roles
	// ----------------------------------------
	localparam int          IRQ_PIN    = 7;
	localparam int          CS_PIN     = 6;

	// ----------------------------------------
	// Timer prescale terminal counts
	// ----------------------------------------
	localparam logic [9:0]  DIV1_LAST    = 10'h000;
	localparam logic [9:0]  DIV8_LAST    = 10'h007;
	localparam logic [9:0]  DIV64_LAST   = 10'h03F;
	localparam logic [9:0]  DIV1024_LAST = 10'h3FF;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic       rnw;
		logic       rsel;
		logic       cs1;
		logic [9:0] addr;
	} bus_req_t;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] data;
	} port_regs_t;

	typedef enum logic [4:0] {
		TGT_NONE  = 5'b00001,
		TGT_ROM   = 5'b00010,
		TGT_RAM   = 5'b00100,
		TGT_PORT  = 5'b01000,
		TGT_TIMER = 5'b10000
	} target_t;

	typedef enum logic [1:0] {
		TMR_RUN     = 2'b01,
		TMR_EXPIRED = 2'b10
	} tmr_state_t;

	// Prescale terminal count for a rate select code
	function automatic logic [9:0] div_last(input logic [1:0] sel);
		unique case (sel)
			2'd0: div_last = DIV1_LAST;
			2'd1: div_last = DIV8_LAST;
			2'd2: div_last = DIV64_LAST;
			2'd3: div_last = DIV1024_LAST;
		endcase
	endfunction : div_last

endpackage : combo_pkg

// *** rtl/interval_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module interval_timer
	import combo_pkg::*;
(
	// Clock and clear
	input  wire logic       ref_clk,
	input  wire logic       clear,
	// Access from the bus decode
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [3:0] reg_sel,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	// Interrupt request, active high
	output logic            irq
);

	logic [7:0]  count_q;
	logic [9:0]  pre_q;
	logic [1:0]  rate_q;
	logic        irq_en_q;
	tmr_state_t  state_q;
	logic        tick;
	logic        wrap;

	// ----------------------------------------
	// Prescaler and counter
	// ----------------------------------------

	// Expired state counts at the undivided rate
	assign tick = (state_q == TMR_EXPIRED) || (pre_q == div_last(rate_q));
	assign wrap = tick && (count_q == BYTE_CLEAR);

	// Prescaler restarts on each load
	always_ff @(posedge ref_clk) begin
		if (clear || wr_en || tick) begin
			pre_q <= 10'h000;
		end else begin
			pre_q <= pre_q + 10'h001;
		end
	end

	// Count loads on a write, otherwise keeps counting down
	always_ff @(posedge ref_clk) begin
		if (clear) begin
			count_q <= BYTE_CLEAR;
		end else if (wr_en) begin
			count_q <= wr_data;
		end else if (tick) begin
			count_q <= count_q - 8'h01;
		end
	end

	// Rate select and interrupt enable follow the address used
	always_ff @(posedge ref_clk) begin
		if (clear) begin
			rate_q   <= 2'd0;
			irq_en_q <= 1'b0;
		end else if (wr_en) begin
			rate_q   <= reg_sel[1:0];
			irq_en_q <= reg_sel[3];
		end else if (rd_en && !reg_sel[0]) begin
			irq_en_q <= reg_sel[3];
		end
	end

	// Expiry flag: a wrap in the same cycle as a count read wins
	always_ff @(posedge ref_clk) begin
		if (clear) begin
			state_q <= TMR_RUN;
		end else if (wrap) begin
			state_q <= TMR_EXPIRED;
		end else if (wr_en || (rd_en && !reg_sel[0])) begin
			state_q <= TMR_RUN;
		end
	end

	// ----------------------------------------
	// Read view and interrupt
	// ----------------------------------------
	always_comb begin
		if (reg_sel[0]) begin
			rd_data = {state_q == TMR_EXPIRED, 7'h00};
		end else begin
			rd_data = count_q;
		end
	end

	assign irq = irq_en_q && (state_q == TMR_EXPIRED);

endmodule : interval_timer

`default_nettype wire

// *** bench/cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------
// Processor side of the bus, one cycle per access
// ------
module cpu_model
	import combo_pkg::*;
(
	// Clock
	input  wire logic       ref_clk,
	// Bus
	output logic      [9:0] addr,
	output logic            rsel,
	output logic            cs1,
	output logic            rnw,
	output logic      [7:0] dout,
	input  wire logic [7:0] din,
	input  wire logic       din_oe
);
	logic seen_oe;    // Device drove the bus in the last access

	// Idle is a read of an unmapped page, so nothing answers
	initial begin
		seen_oe = 1'b0;
		addr = 10'h000;
		rsel = 1'b0;
		cs1  = 1'b0;
		rnw  = 1'b1;
		dout = 8'h00;
	end

	// Request off the falling edge, taken on the rising edge; answer a cycle on
	task automatic cyc(input logic w, input logic r, input logic c, input logic [9:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge ref_clk);
		rnw  = ~w;
		rsel = r;
		cs1  = c;
		addr = a;
		dout = w ? d : ~dout; // Released write data shows no stale byte
		@(negedge ref_clk);
		seen_oe = din_oe;
		q    = din_oe ? din : ~din; // Undriven bus shows no valid byte
		rnw  = 1'b1;
		rsel = 1'b0;
		cs1  = 1'b0;
		addr = 10'h000;
	endtask : cyc
endmodule : cpu_model

`default_nettype wire

// *** bench/combo_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------
// Port-level checks of the combo block
// ------
module combo_asserts
	import combo_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       init_clear_n,
	// Bus
	input wire logic [9:0] cpu_address_lines,
	input wire logic       rom_select_line,
	input wire logic       chip_select_1,
	input wire logic       read_not_write,
	input wire logic [7:0] cpu_data_bus_in,
	input wire logic       cpu_data_bus_oe,
	// Pins
	input wire logic [7:0] port_a_pins_out,
	input wire logic [7:0] port_a_pins_oe,
	input wire logic [7:0] port_a_pullup_en,
	input wire logic [7:0] port_b_pins_in,
	input wire logic [7:0] port_b_pins_out,
	input wire logic [7:0] port_b_pins_oe,
	input wire logic [7:0] port_b_pullup_en,
	input wire logic       timer_interrupt_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Access steps of the port page
	sequence io_sel;
		!rom_select_line && !chip_select_1 && cpu_address_lines[9:6] == IO_PAGE
			&& port_b_pins_in[CS_PIN] == CS_ACTIVE && init_clear_n;
	endsequence
	sequence a_dir_wr;
		io_sel ##0 !read_not_write && cpu_address_lines[2:0] == {1'b0, OFS_A_DIR};
	endsequence
	sequence a_data_rd;
		io_sel ##0 read_not_write && cpu_address_lines[2:0] == {1'b0, OFS_A_DATA};
	endsequence

	AST_BUS_OFF_CLR: assert property (!init_clear_n |-> !cpu_data_bus_oe)
		else $error("bus driven during clear");
	AST_CLR_PORTS: assert property (!init_clear_n |=>
		port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00) else $error("ports not cleared");
	AST_CLR_IRQ: assert property (!init_clear_n |=> timer_interrupt_n)
		else $error("interrupt after clear");
	AST_READ_ANSWER: assert property (a_data_rd |=> cpu_data_bus_oe || !init_clear_n)
		else $error("read not answered");
	AST_OE_ONLY_READ: assert property (cpu_data_bus_oe |-> $past(read_not_write)
		&& $past(port_b_pins_in[CS_PIN]) == CS_ACTIVE && $past(init_clear_n)) else $error("bus driven off read");
	AST_INPUT_HIGH: assert property ((port_a_pins_out | port_a_pins_oe) == 8'hFF
		&& port_a_pullup_en == ~port_a_pins_oe) else $error("input pin not held high");
	AST_B_ROLES: assert property (port_b_pullup_en[7:6] == 2'b00 && !port_b_pins_oe[CS_PIN])
		else $error("port B bit 6 or 7 wrong");
	AST_IRQ_PIN: assert property (!timer_interrupt_n |->
		port_b_pins_oe[IRQ_PIN] && !port_b_pins_out[IRQ_PIN]) else $error("irq pin not low");
	AST_DIR_WRITE: assert property (a_dir_wr |=> port_a_pins_oe == $past(cpu_data_bus_in))
		else $error("direction write lost");
	AST_READ_KEEPS: assert property (read_not_write && init_clear_n |=>
		$stable(port_a_pins_out) && $stable(port_a_pins_oe)) else $error("port changed on read");
endmodule : combo_asserts

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top
	import combo_pkg::*;
();
	// ------
	// Signals
	// ------
	logic       ref_clk, rst, init_clear_n, rsel, cs1, rnw, rd_oe, irq_n;
	logic [9:0] addr;
	logic [7:0] wd, rd, a_out, a_oe, a_pu, b_out, b_oe, b_pu, ext_a, ext_b, q;
	wire  logic [7:0] a_pin, b_pin;
	int         num_errors, n_compared;

	// Pin level from device driver, else outside drive
	assign a_pin = (a_oe & a_out) | (~a_oe & ext_a);
	assign b_pin = (b_oe & b_out) | (~b_oe & ext_b);

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	rom_ram_io_port_combo #(.ROM_SEED(8'h5A)) uut (.ref_clk, .rst, .init_clear_n,
		.cpu_address_lines(addr), .rom_select_line(rsel), .chip_select_1(cs1),
		.read_not_write(rnw), .cpu_data_bus_in(wd), .cpu_data_bus_out(rd), .cpu_data_bus_oe(rd_oe),
		.port_a_pins_in(a_pin), .port_a_pins_out(a_out), .port_a_pins_oe(a_oe), .port_a_pullup_en(a_pu),
		.port_b_pins_in(b_pin), .port_b_pins_out(b_out), .port_b_pins_oe(b_oe), .port_b_pullup_en(b_pu),
		.timer_interrupt_n(irq_n));
	cpu_model cpu (.ref_clk, .addr, .rsel, .cs1, .rnw, .dout(wd), .din(rd), .din_oe(rd_oe));

	// Port page accesses
	task automatic io_wr(input logic [1:0] o, input logic [7:0] d);
		cpu.cyc(1'b1, 1'b0, 1'b0, {IO_PAGE, 4'h0, o}, d, q);
	endtask : io_wr
	task automatic io_rd(input logic [1:0] o);
		cpu.cyc(1'b0, 1'b0, 1'b0, {IO_PAGE, 4'h0, o}, 8'h00, q);
	endtask : io_rd

	task automatic t_reset;
		`CHK(a_oe, 8'h00);
		`CHK(b_pu, 8'h3F);
		`CHK(a_out, 8'hFF);
		`CHK(irq_n, 1'b1);
		io_rd(OFS_B_DIR);
		`CHK(q, 8'h00);
		io_rd(OFS_A_DATA);
		`CHK(q, 8'h3C);
		$display("reset test done");
	endtask : t_reset

	task automatic t_port;
		io_wr(OFS_A_DIR, 8'hF0);
		io_wr(OFS_A_DATA, 8'hA5);
		`CHK(a_oe, 8'hF0);
		`CHK(a_out, 8'hAF);
		`CHK(a_pu, 8'h0F);
		io_rd(OFS_A_DATA);
		`CHK(q, 8'hAC);
		io_rd(OFS_A_DIR);
		`CHK(a_out, 8'hAF);
		io_wr(OFS_B_DIR, 8'hFF);
		io_wr(OFS_B_DATA, 8'h20);
		`CHK(b_oe, 8'hBF);
		`CHK(b_out[5], 1'b1);
		io_wr(OFS_B_DIR, 8'h00);
		$display("port test done");
	endtask : t_port

	task automatic t_select;
		ext_b[CS_PIN] = 1'b0;
		io_wr(OFS_A_DATA, 8'h00);
		`CHK(a_out, 8'hAF);
		io_rd(OFS_A_DIR);
		`CHK(cpu.seen_oe, 1'b0);
		ext_b[CS_PIN] = 1'b1;
		cpu.cyc(1'b0, 1'b0, 1'b1, {IO_PAGE, 6'h00}, 8'h00, q);
		`CHK(cpu.seen_oe, 1'b0);
		io_rd(OFS_B_DATA);
		`CHK(cpu.seen_oe, 1'b1);
		`CHK(q, 8'hFF);
		$display("select test done");
	endtask : t_select

	task automatic t_mem;
		logic [9:0] a;
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 10'h000 : (i == 1) ? 10'h123 : 10'h3FF;
			cpu.cyc(1'b1, 1'b0, 1'b1, {RAM_PAGE, a[5:0]}, a[7:0] ^ 8'h96, q);
			cpu.cyc(1'b0, 1'b1, 1'b0, a, 8'h00, q);
			`CHK(q, a[7:0] ^ {4{a[9:8]}} ^ 8'h5A);
		end
		cpu.cyc(1'b0, 1'b0, 1'b1, {RAM_PAGE, 6'h23}, 8'h00, q);
		`CHK(q, 8'hB5);
		$display("memory test done");
	endtask : t_mem

	task automatic t_timer;
		int n;
		cpu.cyc(1'b1, 1'b0, 1'b0, {IO_PAGE, 6'h0C}, 8'h02, q);
		n = 0;
		while (irq_n !== 1'b0 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(irq_n, 1'b0);
		if (n == 40) report_and_stop();
		`CHK(b_oe[IRQ_PIN], 1'b1);
		@(negedge ref_clk);
		init_clear_n = 1'b0;
		@(negedge ref_clk);
		init_clear_n = 1'b1;
		`CHK(irq_n, 1'b1);
		`CHK(a_oe, 8'h00);
		$display("timer test done");
	endtask : t_timer

	task automatic t_tmr_status;
		cpu.cyc(1'b1, 1'b0, 1'b0, {IO_PAGE, 6'h05}, 8'h02, q);
		repeat (30) @(negedge ref_clk);
		cpu.cyc(1'b0, 1'b0, 1'b0, {IO_PAGE, 6'h07}, 8'h00, q);
		`CHK(q, 8'h80);
		`CHK(irq_n, 1'b1);
		cpu.cyc(1'b0, 1'b0, 1'b0, {IO_PAGE, 6'h06}, 8'h00, q);
		cpu.cyc(1'b0, 1'b0, 1'b0, {IO_PAGE, 6'h07}, 8'h00, q);
		`CHK(q, 8'h00);
		$display("timer status test done");
	endtask : t_tmr_status

	// Verdict and end of run
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		rst = 1'b1;
		init_clear_n = 1'b1;
		ext_a = 8'h3C;
		ext_b = 8'hFF;
		num_errors = 0;
		n_compared = 0;
		repeat (3) @(negedge ref_clk);
		`CHK(rd_oe, 1'b0);
		rst = 1'b0;
		t_reset();
		t_port();
		t_select();
		t_mem();
		t_timer();
		t_tmr_status();
		report_and_stop();
	end
endmodule : tb_top

bind rom_ram_io_port_combo combo_asserts chk (.ref_clk, .rst, .init_clear_n, .cpu_address_lines,
	.rom_select_line, .chip_select_1, .read_not_write, .cpu_data_bus_in, .cpu_data_bus_oe,
	.port_a_pins_out, .port_a_pins_oe, .port_a_pullup_en, .port_b_pins_in, .port_b_pins_out,
	.port_b_pins_oe, .port_b_pullup_en, .timer_interrupt_n);

`default_nettype wire
